//--- logic/alarm_hist_regs.svh
// constants for the alarm history recorder
`ifndef ALARM_HIST_REGS_SVH
`define ALARM_HIST_REGS_SVH

`define AH_DEPTH 10
`define AH_IDX_W 4
`define AH_CODE_W 12
`define AH_TIME_W 32
`define AH_DISP_W 20
`define AH_BCD_W 40
`define AH_BCD_DIGITS 10
`define AH_SHIFT_STEPS 32

`define AH_CLK_KHZ 250000
`define AH_TICK_MS 100
`define AH_TICK_CYC (`AH_TICK_MS * `AH_CLK_KHZ)
`define AH_TICK_W 25
`define AH_HOLD_MS 1000
`define AH_HOLD_CYC (`AH_HOLD_MS * `AH_CLK_KHZ)
`define AH_HOLD_W 28
`define AH_REPEAT_S 3600
`define AH_REPEAT_TICKS (`AH_REPEAT_S * 1000 / `AH_TICK_MS)

`define AH_KEY_MODE 0
`define AH_KEY_UP 1
`define AH_KEY_DOWN 2
`define AH_KEY_SHIFT 3

`define AH_GLYPH_BLANK 4'ha
`define AH_GLYPH_DASH 4'hb
`define AH_GLYPH_F 4'hf
`define AH_FUNC_NUM 12'h000

`endif

//--- logic/alarm_history_recorder.sv
// alarm history log with front panel browsing
// Notes on behaviour
// - keep up to ten alarms, each recallable
// - entry holds alarm code and raise time
// - timestamp counts 100 ms since power-on
// - 32-bit stamp lasts about thirteen years
// - same code as the newest entry within one hour not stored
// - empty log shows dashes, not a code
// - alarm reset and main power keep log
// - only the clear function or rst_b erases the log
// - one second shift hold shows newest entry
// - down steps older, up steps newer
// - left digit is index, larger is older
// - shift cycles low, middle, top time digits
// - mode key returns to function code display
`timescale 1ns/1ps
`default_nettype none
`include "alarm_hist_regs.svh"
module alarm_history_recorder #(
	parameter int TICK_CYC = `AH_TICK_CYC, // cycles per 100 ms
	parameter int HOLD_CYC = `AH_HOLD_CYC // cycles of key hold to enter
) (
	input wire logic mclk, // system clock, 250 MHz
	input wire logic rst_b, // control power-on reset, active low
	input wire logic alarm_raise, // one-cycle pulse, alarm raised
	input wire logic [`AH_CODE_W-1:0] alarm_code, // three bcd digits
	input wire logic history_clear_function, // pulse, erase the log
	input wire logic func_selected, // menu sits on history view
	input wire logic key_mode_pin, // menu/set key, high pressed
	input wire logic key_up_pin, // up key, high pressed
	input wire logic key_down_pin, // down key, high pressed
	input wire logic key_shift_pin, // select/shift key, high pressed
	output logic [`AH_DISP_W-1:0] disp_glyphs, // five glyphs, left first
	output logic view_active, // entry view is open
	output logic [`AH_IDX_W-1:0] entry_count, // entries held
	output logic [`AH_TIME_W-1:0] elapsed_time // 100 ms ticks
);
	localparam logic [`AH_TICK_W-1:0] TICK_LAST =
		`AH_TICK_W'(TICK_CYC - 1);
	localparam logic [`AH_HOLD_W-1:0] HOLD_LAST =
		`AH_HOLD_W'(HOLD_CYC - 1);
	localparam logic [`AH_TIME_W-1:0] REPEAT_TICKS =
		`AH_TIME_W'(`AH_REPEAT_TICKS);
	localparam logic [`AH_IDX_W-1:0] DEPTH = `AH_IDX_W'(`AH_DEPTH);

	typedef struct packed {
		logic [3:0] key_s1_ff;
		logic [3:0] key_s2_ff;
		logic [3:0] key_prev_ff;
		logic [`AH_TICK_W-1:0] tick_ff;
		logic [`AH_HOLD_W-1:0] hold_ff;
		logic [`AH_TIME_W-1:0] now_ff;
		history_pkg::entry_s [`AH_DEPTH-1:0] log_ff;
		logic [`AH_IDX_W-1:0] count_ff;
		logic [`AH_IDX_W-1:0] sel_ff;
		history_pkg::view_e view_ff;
		logic [`AH_DISP_W-1:0] disp_ff;
		logic view_on_ff;
	} state_s;

	state_s st_ff;
	state_s nxt_st;
	logic [`AH_BCD_W-1:0] stamp_bcd;
	logic [3:0] pressed;
	logic dup;
	history_pkg::entry_s cur;

	assign cur = st_ff.log_ff[st_ff.sel_ff];

	// time digits are refreshed every 33 cycles, far below eye rate
	bin_to_bcd u_bcd (
		.mclk(mclk),
		.rst_b(rst_b),
		.value(cur.stamp),
		.bcd(stamp_bcd)
	);

	always_comb begin
		nxt_st = st_ff;
		pressed = st_ff.key_s2_ff & ~st_ff.key_prev_ff;
		dup = 1'b0;

		// panel keys are asynchronous, two stages before use
		nxt_st.key_s1_ff = {key_shift_pin, key_down_pin, key_up_pin,
			key_mode_pin};
		nxt_st.key_s2_ff = st_ff.key_s1_ff;
		nxt_st.key_prev_ff = st_ff.key_s2_ff;

		if (st_ff.tick_ff == TICK_LAST) begin
			nxt_st.tick_ff = '0;
			if (st_ff.now_ff != '1)
				nxt_st.now_ff = st_ff.now_ff + 1'b1;
		end else begin
			nxt_st.tick_ff = st_ff.tick_ff + 1'b1;
		end

		if (history_clear_function) begin
			nxt_st.count_ff = '0;
			nxt_st.sel_ff = '0;
			nxt_st.log_ff = '0;
		end

		// recording after the clear, so a same-cycle alarm survives
		if (alarm_raise) begin
			// repeat filter against the newest entry
			dup = !history_clear_function && st_ff.count_ff != '0 &&
				alarm_code == st_ff.log_ff[0].code &&
				(st_ff.now_ff - st_ff.log_ff[0].stamp) < REPEAT_TICKS;
			if (!dup) begin
				// shift down, oldest falls off the end
				for (int i = `AH_DEPTH - 1; i > 0; i--)
					nxt_st.log_ff[i] = nxt_st.log_ff[i-1];
				nxt_st.log_ff[0].code = alarm_code;
				nxt_st.log_ff[0].stamp = st_ff.now_ff;
				if (nxt_st.count_ff != DEPTH)
					nxt_st.count_ff = nxt_st.count_ff + 1'b1;
			end
		end

		case (st_ff.view_ff)
		history_pkg::VIEW_FUNC: begin
			// hold shift about one second to enter
			if (func_selected && st_ff.key_s2_ff[`AH_KEY_SHIFT]) begin
				if (st_ff.hold_ff == HOLD_LAST) begin
					nxt_st.hold_ff = '0;
					nxt_st.view_ff = history_pkg::VIEW_CODE;
					nxt_st.sel_ff = '0;
				end else begin
					nxt_st.hold_ff = st_ff.hold_ff + 1'b1;
				end
			end else begin
				nxt_st.hold_ff = '0;
			end
		end
		history_pkg::VIEW_CODE: begin
			// step older on down, newer on up
			if (pressed[`AH_KEY_DOWN] &&
				st_ff.sel_ff + 1'b1 < nxt_st.count_ff)
				nxt_st.sel_ff = st_ff.sel_ff + 1'b1;
			else if (pressed[`AH_KEY_UP] && st_ff.sel_ff != '0)
				nxt_st.sel_ff = st_ff.sel_ff - 1'b1;
			if (pressed[`AH_KEY_SHIFT] && st_ff.count_ff != '0)
				nxt_st.view_ff = history_pkg::VIEW_TIME_LO;
		end
		// low, middle, top, then back to code
		history_pkg::VIEW_TIME_LO: begin
			if (pressed[`AH_KEY_SHIFT])
				nxt_st.view_ff = history_pkg::VIEW_TIME_MID;
		end
		history_pkg::VIEW_TIME_MID: begin
			if (pressed[`AH_KEY_SHIFT])
				nxt_st.view_ff = history_pkg::VIEW_TIME_HI;
		end
		history_pkg::VIEW_TIME_HI: begin
			if (pressed[`AH_KEY_SHIFT])
				nxt_st.view_ff = history_pkg::VIEW_CODE;
		end
		default: begin
			nxt_st.view_ff = history_pkg::VIEW_FUNC;
		end
		endcase

		// a clear while browsing leaves nothing to show time for
		if (history_clear_function && !alarm_raise &&
			st_ff.view_ff != history_pkg::VIEW_FUNC)
			nxt_st.view_ff = history_pkg::VIEW_CODE;

		// mode key leaves the entry view
		if (pressed[`AH_KEY_MODE] &&
			st_ff.view_ff != history_pkg::VIEW_FUNC) begin
			nxt_st.view_ff = history_pkg::VIEW_FUNC;
			nxt_st.hold_ff = '0;
		end

		if (nxt_st.sel_ff >= nxt_st.count_ff && nxt_st.count_ff != '0)
			nxt_st.sel_ff = nxt_st.count_ff - 1'b1;

		nxt_st.view_on_ff = st_ff.view_ff != history_pkg::VIEW_FUNC;

		case (st_ff.view_ff)
		history_pkg::VIEW_FUNC: begin
			nxt_st.disp_ff = {`AH_GLYPH_F, `AH_GLYPH_DASH, `AH_FUNC_NUM};
		end
		history_pkg::VIEW_CODE: begin
			if (st_ff.count_ff == '0)
				nxt_st.disp_ff = {`AH_GLYPH_BLANK, {4{`AH_GLYPH_DASH}}};
			else
				nxt_st.disp_ff = {st_ff.sel_ff, `AH_GLYPH_BLANK, cur.code};
		end
		history_pkg::VIEW_TIME_LO: begin
			nxt_st.disp_ff = {`AH_GLYPH_DASH, stamp_bcd[15:0]};
		end
		history_pkg::VIEW_TIME_MID: begin
			nxt_st.disp_ff = {`AH_GLYPH_DASH, stamp_bcd[31:16]};
		end
		history_pkg::VIEW_TIME_HI: begin
			nxt_st.disp_ff = {`AH_GLYPH_DASH, `AH_GLYPH_BLANK,
				`AH_GLYPH_BLANK, stamp_bcd[39:32]};
		end
		default: begin
			nxt_st.disp_ff = {`AH_GLYPH_F, `AH_GLYPH_DASH, `AH_FUNC_NUM};
		end
		endcase
	end

	// no alarm reset or main power input touches the log
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign disp_glyphs = st_ff.disp_ff;
	assign view_active = st_ff.view_on_ff;
	assign entry_count = st_ff.count_ff;
	assign elapsed_time = st_ff.now_ff;
endmodule
`default_nettype wire

//--- logic/bin_to_bcd.sv
// free-running binary to decimal converter for the timestamp display
`timescale 1ns/1ps
`default_nettype none
`include "alarm_hist_regs.svh"
module bin_to_bcd (
	input wire logic mclk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic [`AH_TIME_W-1:0] value, // binary value to convert
	output logic [`AH_BCD_W-1:0] bcd // ten decimal digits, latest result
);
	typedef struct packed {
		logic [`AH_BCD_W+`AH_TIME_W-1:0] sh_ff;
		logic [5:0] cnt_ff;
		logic [`AH_BCD_W-1:0] bcd_ff;
	} conv_s;

	conv_s st_ff;
	conv_s nxt_st;
	logic [`AH_BCD_W-1:0] adj;

	// add three to every digit of five or more before each shift
	genvar g;
	generate
		for (g = 0; g < `AH_BCD_DIGITS; g++) begin : g_dig
			logic [3:0] d;
			assign d = st_ff.sh_ff[`AH_TIME_W+g*4 +: 4];
			assign adj[g*4 +: 4] = (d >= 4'h5) ? d + 4'h3 : d;
		end
	endgenerate

	always_comb begin
		nxt_st = st_ff;
		if (st_ff.cnt_ff == 6'h00) begin
			nxt_st.sh_ff = {{`AH_BCD_W{1'b0}}, value};
			nxt_st.cnt_ff = 6'(`AH_SHIFT_STEPS);
		end else begin
			nxt_st.sh_ff = {adj[`AH_BCD_W-2:0],
				st_ff.sh_ff[`AH_TIME_W-1:0], 1'b0};
			nxt_st.cnt_ff = st_ff.cnt_ff - 6'h01;
			if (st_ff.cnt_ff == 6'h01)
				nxt_st.bcd_ff = {adj[`AH_BCD_W-2:0],
					st_ff.sh_ff[`AH_TIME_W-1]};
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign bcd = st_ff.bcd_ff;
endmodule
`default_nettype wire

//--- logic/history_pkg.sv
// types shared by the alarm history recorder
`include "alarm_hist_regs.svh"
package history_pkg;
	typedef enum logic [2:0] {
		VIEW_FUNC,
		VIEW_CODE,
		VIEW_TIME_LO,
		VIEW_TIME_MID,
		VIEW_TIME_HI
	} view_e;

	typedef struct packed {
		logic [`AH_CODE_W-1:0] code;
		logic [`AH_TIME_W-1:0] stamp;
	} entry_s;
endpackage

//--- tb/ahr_monitor.sv
// concurrent checks on the alarm history recorder ports
`timescale 1ns/1ps
`default_nettype none
`include "alarm_hist_regs.svh"
module ahr_monitor (
	input wire logic mclk, // clock
	input wire logic rst_b, // reset, active low
	input wire logic alarm_raise, // alarm pulse
	input wire logic history_clear_function, // clear pulse
	input wire logic func_selected, // on history view
	input wire logic key_mode_pin, // menu/set key
	input wire logic key_shift_pin, // select/shift key
	input wire logic [`AH_DISP_W-1:0] disp_glyphs, // display
	input wire logic view_active, // entry view open
	input wire logic [`AH_IDX_W-1:0] entry_count, // entries held
	input wire logic [`AH_TIME_W-1:0] elapsed_time // ticks
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	a_count_max: assert property (entry_count <= 4'ha)
		else $error("count above ten");
	a_first_kept: assert property (alarm_raise &&
		!history_clear_function && entry_count == 4'h0
		|=> entry_count == 4'h1) else $error("alarm not stored");
	a_count_hold: assert property (!alarm_raise &&
		!history_clear_function |=> $stable(entry_count))
		else $error("log changed on its own");
	a_time_step: assert property (
		elapsed_time - $past(elapsed_time) <= 32'h1)
		else $error("time jumped");
	// display and view flag both lag the view state by one stage
	a_empty_dash: assert property (entry_count == 4'h0
		##1 view_active |-> disp_glyphs == 20'habbbb)
		else $error("empty mark missing");
	// pin seen four samples back: two sync stages plus two registers
	a_leave_key: assert property ($fell(view_active)
		|-> $past(key_mode_pin, 4)) else $error("view left");
	a_enter_hold: assert property ($rose(view_active)
		|-> $past(func_selected, 2) && $past(key_shift_pin, 4))
		else $error("view opened");
	a_full_stays: assert property (entry_count == 4'ha &&
		alarm_raise && !history_clear_function
		|=> entry_count == 4'ha) else $error("full log shrank");
	a_clear_empty: assert property (history_clear_function &&
		!alarm_raise |=> entry_count == 4'h0)
		else $error("clear ignored");
endmodule
bind alarm_history_recorder ahr_monitor u_mon (.mclk, .rst_b,
	.alarm_raise, .history_clear_function, .func_selected,
	.key_mode_pin, .key_shift_pin, .disp_glyphs, .view_active,
	.entry_count, .elapsed_time);
`default_nettype wire

//--- tb/alarm_history_recorder_tb_top.sv
// self-checking bench for the alarm history recorder
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("[ERR] %0t %h %h", $time, a, b); end end
module alarm_history_recorder_tb_top;
	logic mclk = 1'b0, rst_b = 1'b0, alarm_raise = 1'b0;
	logic history_clear_function = 1'b0;
	logic [11:0] alarm_code = 12'h000;
	wire logic func_selected, key_mode_pin, key_up_pin;
	wire logic key_down_pin, key_shift_pin;
	logic [19:0] disp_glyphs;
	logic view_active;
	logic [3:0] entry_count;
	logic [31:0] elapsed_time;
	int errors = 0, num_checks = 0, seed = 99, cyc = 0;
	logic [11:0] qc[$];
	int qs[$];
	initial forever #2 mclk = ~mclk;
	always @(posedge mclk) if (rst_b) cyc++;
	alarm_history_recorder #(.TICK_CYC(10), .HOLD_CYC(20)) u_dut (
		.mclk, .rst_b, .alarm_raise, .alarm_code, .history_clear_function,
		.func_selected, .key_mode_pin, .key_up_pin, .key_down_pin,
		.key_shift_pin, .disp_glyphs, .view_active, .entry_count,
		.elapsed_time);
	panel_keys u_panel (.mclk, .func_selected, .key_mode_pin,
		.key_up_pin, .key_down_pin, .key_shift_pin);
	function automatic logic [3:0] rd();
		return 4'(unsigned'($random(seed)) % 10);
	endfunction
	function automatic logic [3:0] dg(int s, int n);
		return 4'((s / (10 ** n)) % 10);
	endfunction
	function automatic logic [19:0] tv(int i, int v);
		int s;
		s = qs[i];
		case (v)
			0: return {4'hb, dg(s, 3), dg(s, 2), dg(s, 1), dg(s, 0)};
			1: return {4'hb, dg(s, 7), dg(s, 6), dg(s, 5), dg(s, 4)};
			2: return {4'hb, 8'haa, dg(s, 9), dg(s, 8)};
			default: return {4'(i), 4'ha, qc[i]};
		endcase
	endfunction
	task summarize();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// mid-tick raise keeps the stamp clear of a tick edge
	task raise(logic [11:0] c, logic clr);
		while (cyc % 10 != 5) @(negedge mclk);
		alarm_code = c;
		alarm_raise = 1'b1;
		history_clear_function = clr;
		// set wins: a clear in the same cycle leaves only this alarm
		if (clr) begin
			qc.delete();
			qs.delete();
		end
		if (!(qc.size() > 0 && qc[0] == c)) begin
			qc.push_front(c);
			qs.push_front(cyc / 10);
		end
		if (qc.size() > 10) begin
			void'(qc.pop_back());
			void'(qs.pop_back());
		end
		@(negedge mclk);
		alarm_raise = 1'b0;
		history_clear_function = 1'b0;
		`CHK(entry_count, 4'(qc.size()))
	endtask
	task see(logic [19:0] e);
		repeat (70) @(negedge mclk);
		`CHK(disp_glyphs, e)
	endtask
	initial begin
		#400000;
		errors++;
		summarize();
	end
	initial begin
		repeat (4) @(negedge mclk);
		rst_b = 1'b1;
		@(negedge mclk);
		`CHK(disp_glyphs, 20'hfb000)
		u_panel.hold_shift();
		see(20'habbbb);
		u_panel.tap(3);
		see(20'habbbb);
		u_panel.tap(0);
		see(20'hfb000);
		u_panel.set_menu(1'b0);
		u_panel.hold_shift();
		see(20'hfb000);
		`CHK(view_active, 1'b0)
		u_panel.set_menu(1'b1);
		for (int i = 0; i < 12; i++) raise({rd(), rd(), rd()}, 1'b0);
		raise(qc[0], 1'b0);
		`CHK(elapsed_time, 32'(cyc / 10))
		u_panel.hold_shift();
		see(tv(0, 3));
		for (int i = 1; i < 11; i++) begin
			u_panel.tap(2);
			see(tv(i > 9 ? 9 : i, 3));
		end
		u_panel.tap(1);
		see(tv(8, 3));
		for (int v = 0; v < 4; v++) begin
			u_panel.tap(3);
			see(tv(8, v));
		end
		u_panel.tap(0);
		see(20'hfb000);
		`CHK(view_active, 1'b0)
		raise(qc[0], 1'b1);
		@(negedge mclk);
		history_clear_function = 1'b1;
		@(negedge mclk);
		history_clear_function = 1'b0;
		`CHK(entry_count, 4'h0)
		summarize();
	end
endmodule
`default_nettype wire

//--- tb/panel_keys.sv
// front panel model: presses keys like an operator
`timescale 1ns/1ps
`default_nettype none
module panel_keys (
	input wire logic mclk, // clock
	output logic func_selected, // menu on history view
	output logic key_mode_pin, // menu/set key
	output logic key_up_pin, // up key
	output logic key_down_pin, // down key
	output logic key_shift_pin // select/shift key
);
	logic [3:0] k = 4'h0;
	logic menu_on = 1'b1;
	assign func_selected = menu_on;
	assign {key_shift_pin, key_down_pin, key_up_pin, key_mode_pin} = k;
	// menu moves onto or off the history view
	task set_menu(logic on);
		@(negedge mclk);
		menu_on = on;
	endtask
	task hold_shift();
		@(negedge mclk);
		k[3] = 1'b1;
		// well beyond the shortened hold count plus sync
		repeat (40) @(negedge mclk);
		k[3] = 1'b0;
		repeat (8) @(negedge mclk);
	endtask
	// single short press, released between presses
	task tap(int n);
		@(negedge mclk);
		k[n] = 1'b1;
		repeat (6) @(negedge mclk);
		k[n] = 1'b0;
		repeat (6) @(negedge mclk);
	endtask
endmodule
`default_nettype wire
